// >>> hw/ild_top.sv
// Summary of operation
// [R1] Top ten sample bits at or above upper threshold activate the indicator.
// [R2] Top ten sample bits at or below lower threshold meet the lower threshold.
// [R3] Dwell time is a 20-bit value: minimum time at or below lower threshold.
// [R4] Dwell time zero disables the indicator; software programs at least one.
// [R5] Meeting lower threshold after an upper excursion loads the dwell counter.
// [R6] Rising above lower threshold during dwell reloads the counter and waits.
// [R7] Indicator releases only after the full dwell time at or below lower.
// [R8] Gain control bit 4 inverts both indicators when set.
// [R9] Bit 3 clear: first indicator is active flag, second is its complement.
// [R10] Bit 3 set: interleave select routes detection to first or second.
// [R11] Gain control bits 2 to 0 program the indicator's internal delay.
// [R12] Software opens the register page by sleep bit 5, then sets address.
// [R13] Dwell counter counts down from the loaded value; release when it reaches one.
// [R14] The three-bit delay plus one is the count of clock cycles on both indicators.
`timescale 1ns/1ns
`default_nettype none
module ild_top #(
  parameter int MANT_W = 14
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_n,
  input  wire logic [MANT_W-1:0]              sample_b_mantissa,
  input  wire logic                           interleave_select_b,
  input  wire logic                           ext_port_access_en,
  input  wire logic [ild_pkg::ILD_ADDR_W-1:0] channel_address_pointer,
  input  wire logic                           reg_wr_strobe,
  input  wire logic [ild_pkg::ILD_DATA_W-1:0] reg_wr_data,
  output logic      [ild_pkg::ILD_DATA_W-1:0] reg_rd_data,
  output logic                                level_flag_b_first,
  output logic                                level_flag_b_second
);
  import ild_pkg::*;

  ild_cfg_if cfg ();

  logic [ILD_THR_W-1:0]   sample_top;
  logic                   upper_met;
  logic                   lower_met;
  logic                   enabled;
  ild_state_t             state_reg, state_next;
  logic [ILD_DWELL_W-1:0] cnt_reg,   cnt_next;
  logic                   active;
  logic                   flag_first;
  logic                   flag_second;
  logic [1:0]             flags_dly;

  // The host reaches the registers only after opening the page and pointing
  // the channel address; the block relies on that order. [R12]
  ild_regs u_regs (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .access_en (ext_port_access_en),
    .addr      (channel_address_pointer),
    .wr_strobe (reg_wr_strobe),
    .wr_data   (reg_wr_data),
    .rd_data   (reg_rd_data),
    .cfg       (cfg.regs)
  );

  assign sample_top = sample_b_mantissa[MANT_W-1 -: ILD_THR_W];
  assign upper_met  = sample_top >= cfg.upper_thr; // [R1]
  assign lower_met  = sample_top <= cfg.lower_thr; // [R2]
  assign enabled    = cfg.dwell != ILD_DWELL_RST; // [R4]

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (!enabled) begin
      // A zero dwell turns the detector off and drops any held indication.
      state_next = ILD_IDLE; // [R4]
      cnt_next   = ILD_DWELL_RST;
    end else begin
      case (state_reg)
        ILD_IDLE: begin
          if (upper_met) begin
            state_next = ILD_ACTIVE; // [R1]
          end
        end
        ILD_ACTIVE: begin
          // Upper wins when both thresholds overlap, so the flag stays held.
          if (!upper_met && lower_met) begin
            state_next = ILD_DWELL; // [R5]
            cnt_next   = cfg.dwell; // [R3] [R13]
          end
        end
        ILD_DWELL: begin
          if (upper_met || !lower_met) begin
            state_next = ILD_ACTIVE; // [R6]
            cnt_next   = cfg.dwell; // [R6]
          end else if (cnt_reg == ILD_CNT_ONE) begin
            state_next = ILD_IDLE; // [R7]
            cnt_next   = ILD_DWELL_RST; // [R13]
          end else begin
            cnt_next = cnt_reg - ILD_CNT_ONE; // [R13]
          end
        end
        default: begin
          state_next = ILD_IDLE;
          cnt_next   = ILD_DWELL_RST;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ILD_IDLE;
      cnt_reg   <= ILD_DWELL_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign active         = state_reg != ILD_IDLE;
  assign cfg.active     = active;
  assign cfg.dwell_busy = state_reg == ILD_DWELL;

  // Routing is done before the delay line so a changing interleave select
  // sees the same latency as the flag itself.
  always_comb begin
    if (cfg.interleaved) begin
      flag_first  = cfg.polarity_low ^ (active & ~interleave_select_b); // [R10] [R8]
      flag_second = cfg.polarity_low ^ (active & interleave_select_b); // [R10] [R8]
    end else begin
      flag_first  = cfg.polarity_low ^ active; // [R9] [R8]
      flag_second = ~flag_first; // [R9]
    end
  end

  // Hold-off for converter latency and gain settling. [R11] [R14]
  ild_delay #(
    .W     (2),
    .DEPTH (8)
  ) u_delay (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     ({flag_second, flag_first}),
    .sel     (cfg.delay),
    .dout    (flags_dly)
  );

  assign level_flag_b_first  = flags_dly[0];
  assign level_flag_b_second = flags_dly[1];
endmodule
`default_nettype wire

// >>> hw/ild_pkg.sv
package ild_pkg;

  localparam int          ILD_ADDR_W      = 8;
  localparam int          ILD_DATA_W      = 20;
  localparam int          ILD_THR_W       = 10;
  localparam int          ILD_DWELL_W     = 20;
  localparam int          ILD_GAIN_W      = 5;
  localparam int          ILD_DLY_W       = 3;

  // Channel address offsets of the port B detector registers.
  localparam logic [7:0]  ILD_LOWER_OFS   = 8'h04;
  localparam logic [7:0]  ILD_UPPER_OFS   = 8'h05;
  localparam logic [7:0]  ILD_DWELL_OFS   = 8'h06;
  localparam logic [7:0]  ILD_GAIN_OFS    = 8'h07;
  localparam logic [7:0]  ILD_STATUS_OFS  = 8'h3F;

  // Field positions inside the gain range control register.
  localparam int          ILD_POL_BIT     = 4;
  localparam int          ILD_ILV_BIT     = 3;
  localparam int          ILD_DLY_LSB     = 0;

  localparam logic [9:0]  ILD_LOWER_RST   = 10'h000;
  localparam logic [9:0]  ILD_UPPER_RST   = 10'h000;
  localparam logic [19:0] ILD_DWELL_RST   = 20'h0_0000;
  localparam logic [4:0]  ILD_GAIN_RST    = 5'h00;
  localparam logic [19:0] ILD_DATA_RST    = 20'h0_0000;
  localparam logic [19:0] ILD_CNT_ONE     = 20'h0_0001;

  typedef enum logic [1:0] {
    ILD_IDLE   = 2'b00,
    ILD_ACTIVE = 2'b01,
    ILD_DWELL  = 2'b10
  } ild_state_t;

endpackage

// >>> hw/ild_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ild_cfg_if;
  import ild_pkg::*;
  logic [ILD_THR_W-1:0]   lower_thr;
  logic [ILD_THR_W-1:0]   upper_thr;
  logic [ILD_DWELL_W-1:0] dwell;
  logic                   polarity_low;
  logic                   interleaved;
  logic [ILD_DLY_W-1:0]   delay;
  logic                   active;
  logic                   dwell_busy;

  modport regs (
    output lower_thr,
    output upper_thr,
    output dwell,
    output polarity_low,
    output interleaved,
    output delay,
    input  active,
    input  dwell_busy
  );

  modport core (
    input  lower_thr,
    input  upper_thr,
    input  dwell,
    input  polarity_low,
    input  interleaved,
    input  delay,
    output active,
    output dwell_busy
  );
endinterface
`default_nettype wire

// >>> hw/ild_regs.sv
`timescale 1ns/1ns
`default_nettype none
module ild_regs (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         access_en,
  input  wire logic [ild_pkg::ILD_ADDR_W-1:0] addr,
  input  wire logic                         wr_strobe,
  input  wire logic [ild_pkg::ILD_DATA_W-1:0] wr_data,
  output logic      [ild_pkg::ILD_DATA_W-1:0] rd_data,
  ild_cfg_if.regs                           cfg
);
  import ild_pkg::*;

  logic [ILD_THR_W-1:0]   lower_reg, lower_next;
  logic [ILD_THR_W-1:0]   upper_reg, upper_next;
  logic [ILD_DWELL_W-1:0] dwell_reg, dwell_next;
  logic [ILD_GAIN_W-1:0]  gain_reg,  gain_next;
  logic [ILD_DATA_W-1:0]  rd_reg,    rd_next;
  logic                   wr_ok;

  // Writes only land while the port register page is opened by the sleep bit.
  assign wr_ok = access_en && wr_strobe;

  always_comb begin
    lower_next = lower_reg;
    upper_next = upper_reg;
    dwell_next = dwell_reg;
    gain_next  = gain_reg;
    rd_next    = ILD_DATA_RST;
    if (wr_ok) begin
      case (addr)
        ILD_LOWER_OFS: lower_next = wr_data[ILD_THR_W-1:0];
        ILD_UPPER_OFS: upper_next = wr_data[ILD_THR_W-1:0];
        ILD_DWELL_OFS: dwell_next = wr_data[ILD_DWELL_W-1:0];
        ILD_GAIN_OFS:  gain_next  = wr_data[ILD_GAIN_W-1:0];
        default:       lower_next = lower_reg;
      endcase
    end
    if (access_en) begin
      case (addr)
        ILD_LOWER_OFS:  rd_next = {10'h000, lower_reg};
        ILD_UPPER_OFS:  rd_next = {10'h000, upper_reg};
        ILD_DWELL_OFS:  rd_next = dwell_reg;
        ILD_GAIN_OFS:   rd_next = {15'h0000, gain_reg};
        ILD_STATUS_OFS: rd_next = {18'h0_0000, cfg.dwell_busy, cfg.active};
        default:        rd_next = ILD_DATA_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lower_reg <= ILD_LOWER_RST;
      upper_reg <= ILD_UPPER_RST;
      dwell_reg <= ILD_DWELL_RST;
      gain_reg  <= ILD_GAIN_RST;
      rd_reg    <= ILD_DATA_RST;
    end else begin
      lower_reg <= lower_next;
      upper_reg <= upper_next;
      dwell_reg <= dwell_next;
      gain_reg  <= gain_next;
      rd_reg    <= rd_next;
    end
  end

  assign rd_data          = rd_reg;
  assign cfg.lower_thr    = lower_reg;
  assign cfg.upper_thr    = upper_reg;
  assign cfg.dwell        = dwell_reg;
  assign cfg.polarity_low = gain_reg[ILD_POL_BIT];
  assign cfg.interleaved  = gain_reg[ILD_ILV_BIT];
  assign cfg.delay        = gain_reg[ILD_DLY_LSB +: ILD_DLY_W];
endmodule
`default_nettype wire

// >>> hw/ild_delay.sv
`timescale 1ns/1ns
`default_nettype none
module ild_delay #(
  parameter int W     = 2,
  parameter int DEPTH = 8
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic [W-1:0]             din,
  input  wire logic [$clog2(DEPTH)-1:0] sel,
  output logic      [W-1:0]             dout
);
  logic [W-1:0] pipe_reg  [DEPTH];
  logic [W-1:0] pipe_next [DEPTH];

  always_comb begin
    pipe_next[0] = din;
    for (int i = 1; i < DEPTH; i++) begin
      pipe_next[i] = pipe_reg[i-1];
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!rst_n) begin
        pipe_reg[i] <= '0;
      end else begin
        pipe_reg[i] <= pipe_next[i];
      end
    end
  end

  assign dout = pipe_reg[sel];
endmodule
`default_nettype wire

// >>> verification/ild_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ild_top_properties #(
  parameter int MANT_W = 14
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [MANT_W-1:0] sample_b_mantissa,
  input wire logic              interleave_select_b,
  input wire logic              ext_port_access_en,
  input wire logic [7:0]        channel_address_pointer,
  input wire logic              reg_wr_strobe,
  input wire logic [19:0]       reg_wr_data,
  input wire logic [19:0]       reg_rd_data,
  input wire logic              level_flag_b_first,
  input wire logic              level_flag_b_second
);
  // Shadow settings; indicator checks wait until the delay pipe has flushed after any write.
  logic [9:0] up_q;
  logic [4:0] g_q;
  logic       dz_q;
  logic [3:0] qt_q;
  wire        wr = ext_port_access_en && reg_wr_strobe;
  wire [7:0]  a  = channel_address_pointer;
  wire        on = qt_q >= 4'hC;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || wr) qt_q <= 4'h0;
    else if (!on) qt_q <= qt_q + 4'h1;
    if (!rst_n) begin
      up_q <= 10'h000;
      g_q  <= 5'h00;
      dz_q <= 1'b1;
    end else if (wr) begin
      if (a == 8'h05) up_q <= reg_wr_data[9:0];
      if (a == 8'h06) dz_q <= reg_wr_data == 20'h0_0000;
      if (a == 8'h07) g_q <= reg_wr_data[4:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_hi; on && !dz_q && !g_q[3] && sample_b_mantissa[MANT_W-1 -: 10] >= up_q; endsequence
  sequence s_act; level_flag_b_first != g_q[4]; endsequence
  property p_up; s_hi |-> ##[2:9] s_act; endproperty
  a_up: assert property (p_up)
    else $error("indicator missed an upper crossing");
  property p_rst;
    disable iff (1'b0) !rst_n |=> !level_flag_b_first && !level_flag_b_second;
  endproperty
  a_rst: assert property (p_rst)
    else $error("indicator not idle at reset");
  property p_cmp; on && !g_q[3] |-> level_flag_b_second == !level_flag_b_first; endproperty
  a_cmp: assert property (p_cmp)
    else $error("second indicator not the complement");
  property p_off;
    on && dz_q |-> level_flag_b_first == g_q[4]
      && level_flag_b_second == (g_q[3] ? g_q[4] : !g_q[4]);
  endproperty
  a_off: assert property (p_off)
    else $error("indicator active with zero dwell");
  property p_ilv;
    on && g_q[3] |-> !((level_flag_b_first ^ g_q[4]) && (level_flag_b_second ^ g_q[4]));
  endproperty
  a_ilv: assert property (p_ilv)
    else $error("both interleaved indicators active");
  property p_cls; $past(!ext_port_access_en) |-> reg_rd_data == 20'h0_0000; endproperty
  a_cls: assert property (p_cls)
    else $error("read data with page closed");
  property p_unm;
    $past(ext_port_access_en && !(a inside {8'h04, 8'h05, 8'h06, 8'h07, 8'h3F}))
      |-> reg_rd_data == 20'h0_0000;
  endproperty
  a_unm: assert property (p_unm)
    else $error("unmapped read not zero");
  property p_thr;
    $past(ext_port_access_en && a inside {8'h04, 8'h05}) |-> reg_rd_data[19:10] == 10'h000;
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold wider than ten bits");
  property p_gw; $past(ext_port_access_en && a == 8'h07) |-> reg_rd_data[19:5] == 15'h0000; endproperty
  a_gw: assert property (p_gw)
    else $error("gain control wider than five bits");
endmodule
bind ild_top ild_top_properties #(.MANT_W(MANT_W)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .sample_b_mantissa(sample_b_mantissa),
  .interleave_select_b(interleave_select_b), .ext_port_access_en(ext_port_access_en),
  .channel_address_pointer(channel_address_pointer), .reg_wr_strobe(reg_wr_strobe),
  .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
  .level_flag_b_first(level_flag_b_first), .level_flag_b_second(level_flag_b_second));
`default_nettype wire

// >>> verification/ild_atten_model.sv
`timescale 1ns/1ns
`default_nettype none
module ild_atten_model (
  input  wire logic level_flag_b_first,
  input  wire logic level_flag_b_second,
  input  wire logic pol_low,
  input  wire logic ilv,
  output logic      atten_on
);
  // Interleaved, the attenuator switches in for whichever pin is active once polarity is undone; otherwise for the first pin.
  assign atten_on = ilv ? ((level_flag_b_first ^ pol_low) | (level_flag_b_second ^ pol_low))
                        : (level_flag_b_first ^ pol_low);
endmodule
`default_nettype wire

// >>> verification/tb_input_level_detector_b.sv
`timescale 1ns/1ns
`default_nettype none
module tb_input_level_detector_b;
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        sel       = 1'b0;
  logic        en        = 1'b0;
  logic        stb       = 1'b0;
  logic        pol       = 1'b0;
  logic        ilv       = 1'b0;
  logic [13:0] smp       = 14'h0000;
  logic [7:0]  adr       = 8'h00;
  logic [19:0] wd        = 20'h0_0000;
  logic [19:0] rd;
  logic        f1;
  logic        f2;
  logic        att;
  int          error_cnt = 0;
  int          cmp_count = 0;
  ild_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .sample_b_mantissa(smp),
    .interleave_select_b(sel), .ext_port_access_en(en), .channel_address_pointer(adr),
    .reg_wr_strobe(stb), .reg_wr_data(wd), .reg_rd_data(rd), .level_flag_b_first(f1),
    .level_flag_b_second(f2));
  ild_atten_model far (.level_flag_b_first(f1), .level_flag_b_second(f2), .pol_low(pol),
    .ilv(ilv), .atten_on(att));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    @(negedge sys_clk);
    en = 1'b1;
    adr = a;
    wd = d;
    stb = 1'b1;
    @(negedge sys_clk);
    stb = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [19:0] e, input logic o);
    @(negedge sys_clk);
    en = o;
    adr = a;
    @(negedge sys_clk);
    chk(rd, e);
  endtask
  task automatic cfg(input logic [19:0] dw, input logic [4:0] g);
    wr(8'h04, 20'h0_0100);
    wr(8'h05, 20'h0_0200);
    wr(8'h06, dw);
    wr(8'h07, g);
    pol = g[4];
    ilv = g[3];
    repeat (12) @(negedge sys_clk);
  endtask
  // Counts falling edges until the attenuator reaches the wanted state.
  task automatic meas(input logic [13:0] s, input logic t, input int e);
    int n;
    n = 0;
    smp = s;
    do begin
      @(negedge sys_clk);
      n++;
    end while (att !== t && n < 60);
    if (att !== t) begin
      chk(20'(att), 20'(t));
      finish_test;
    end else chk(20'(n), 20'(e));
  endtask
  task automatic t_regs;
    logic [19:0] m [4];
    m = '{20'h0_03FF, 20'h0_03FF, 20'hF_FFFF, 20'h0_001F};
    for (int i = 0; i < 4; i++) rdc(8'h04 + 8'(i), 20'h0_0000, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04 + 8'(i), 20'hF_FFFF);
      rdc(8'h04 + 8'(i), m[i], 1'b1);
    end
    rdc(8'h05, 20'h0_0000, 1'b0);
    stb = 1'b1;
    wd = 20'h0_0000;
    @(negedge sys_clk);
    stb = 1'b0;
    rdc(8'h05, 20'h0_03FF, 1'b1);
    rdc(8'h20, 20'h0_0000, 1'b1);
  endtask
  task automatic t_level(input logic p, input logic [2:0] d);
    cfg(20'h0_0003, {p, 1'b0, d});
    meas(14'h2000, 1'b1, 2 + d);
    chk(20'(f1), 20'(!p));
    chk(20'(f2), 20'(p));
    rdc(8'h3F, 20'h0_0001, 1'b1);
    smp = 14'h1000;
    // The status read spans the load edge and one count edge of the dwell.
    rdc(8'h3F, 20'h0_0003, 1'b1);
    smp = 14'h1010;
    @(negedge sys_clk);
    meas(14'h1000, 1'b0, 5 + d);
  endtask
  task automatic t_ilv;
    cfg(20'h0_0001, 5'h0B);
    sel = 1'b1;
    meas(14'h2000, 1'b1, 5);
    chk(20'({f1, f2}), 20'h0_0001);
    sel = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(20'({f1, f2}), 20'h0_0002);
    meas(14'h1000, 1'b0, 6);
  endtask
  task automatic t_off;
    cfg(20'h0_0000, 5'h00);
    smp = 14'h3FF0;
    repeat (12) @(negedge sys_clk);
    chk(20'({f1, f2}), 20'h0_0001);
    smp = 14'h0000;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    t_regs;
    t_level(1'b0, 3'h0);
    t_level(1'b1, 3'h7);
    t_ilv;
    t_off;
    finish_test;
  end
endmodule
`default_nettype wire
